/* File: hw/scd_top.sv */
// module: serial clock edge counter with start/stop condition detection
module scd_top
	import scd_pkg::*;
(
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst,
	input  wire logic        i_ce,
	input  wire logic        i_link_clk,
	input  scd_bus_req_t     i_bus,
	input  wire logic        i_scl,
	input  wire logic        i_sda,
	output logic [SCD_DW-1:0] o_rdata,
	output scd_flags_t       o_status
);

	// ------------------------------------------------------------
	// state of both domains
	// ------------------------------------------------------------
	scd_ref_t   r;
	scd_ref_t   next_r;
	scd_link_t  l;
	scd_link_t  next_l;

	// ------------------------------------------------------------
	// crossings
	// ------------------------------------------------------------
	logic [1:0] pins_q;
	logic [1:0] lctl_q;
	logic       ack_q;
	logic       restart_q;
	logic       req_q;
	logic       scl;
	logic       sda;
	logic       l_bus_mode;
	logic       l_ce;

	// pins into the link domain, inverted so reset matches idle-high lines
	scd_sync3 #(
		.W (2)
	) u_pins (
		.i_clk (i_link_clk),
		.i_rst (i_rst),
		.i_en  (1'b1),
		.i_d   ({~i_scl, ~i_sda}),
		.o_q   (pins_q)
	);

	// mode and clock enable into the link domain
	scd_sync3 #(
		.W (2)
	) u_lctl (
		.i_clk (i_link_clk),
		.i_rst (i_rst),
		.i_en  (1'b1),
		.i_d   ({i_ce, r.bus_mode}),
		.o_q   (lctl_q)
	);

	// handshake acknowledge and restart event into the link domain
	scd_sync3 #(
		.W (2)
	) u_lev (
		.i_clk (i_link_clk),
		.i_rst (i_rst),
		.i_en  (1'b1),
		.i_d   ({r.ack_tog, r.restart_tog}),
		.o_q   ({ack_q, restart_q})
	);

	// handshake request into the reference domain
	scd_sync3 #(
		.W (1)
	) u_req (
		.i_clk (i_ref_clk),
		.i_rst (i_rst),
		.i_en  (i_ce),
		.i_d   (l.req_tog),
		.o_q   (req_q)
	);

	assign scl        = ~pins_q[1];
	assign sda        = ~pins_q[0];
	assign l_ce       = lctl_q[1];
	assign l_bus_mode = lctl_q[0];

	// ------------------------------------------------------------
	// link domain: edge and condition detection
	// ------------------------------------------------------------
	logic                 scl_rise;
	logic                 start_cond;
	logic                 stop_cond;
	logic                 restart_ev;
	logic [SCD_CNT_W-1:0] cnt_inc;

	assign scl_rise   = scl & ~l.scl_prev;
	assign start_cond = l_bus_mode & scl & l.scl_prev
		& l.sda_prev & ~sda;
	assign stop_cond  = l_bus_mode & scl & l.scl_prev
		& ~l.sda_prev & sda;
	assign restart_ev = restart_q ^ l.restart_seen;
	assign cnt_inc    = SCD_CNT_W'(l.cnt + SCD_CNT_ONE);

	// ------------------------------------------------------------
	// link domain: next state
	// ------------------------------------------------------------
	always_comb begin
		next_l          = l;
		next_l.scl_prev = scl;
		next_l.sda_prev = sda;

		// counter
		if (restart_ev) begin
			next_l.cnt          = SCD_CNT_RST;
			next_l.restart_seen = restart_q;
		end else if (start_cond) begin
			next_l.cnt = SCD_CNT_RST;
		end else if (scl_rise) begin
			next_l.cnt = cnt_inc;
		end

		// flags follow the counter value
		next_l.flags.count_eight_flag =
			(next_l.cnt == SCD_CNT_EIGHT);
		next_l.flags.count_nine_flag =
			l_bus_mode & (next_l.cnt == SCD_CNT_NINE);

		// start seen: set wins over clear
		if (!l_bus_mode) begin
			next_l.flags.start_seen_flag = 1'b0;
		end else if (start_cond) begin
			next_l.flags.start_seen_flag = 1'b1;
		end else if (scl_rise && l.cnt == SCD_CNT_NINE) begin
			next_l.flags.start_seen_flag = 1'b0;
		end

		// bus busy
		if (!l_bus_mode) begin
			next_l.flags.bus_busy_flag = 1'b0;
		end else if (start_cond) begin
			next_l.flags.bus_busy_flag = 1'b1;
		end else if (stop_cond) begin
			next_l.flags.bus_busy_flag = 1'b0;
		end

		// flag word sender
		case (l.tx)
			SCD_TX_IDLE: begin
				if (l.flags != l.held) begin
					next_l.held    = l.flags;
					next_l.req_tog = ~l.req_tog;
					next_l.tx      = SCD_TX_WAIT;
				end
			end
			SCD_TX_WAIT: begin
				if (ack_q == l.req_tog) begin
					next_l.tx = SCD_TX_IDLE;
				end
			end
			default: begin
				next_l.tx = SCD_TX_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_link_clk or posedge i_rst) begin
		if (i_rst) begin
			l <= SCD_LINK_RST;
		end else if (l_ce) begin
			l <= next_l;
		end
	end

	// ------------------------------------------------------------
	// reference domain: registers and flag capture
	// ------------------------------------------------------------
	logic wr_ctrl;

	assign wr_ctrl = i_bus.wr & (i_bus.addr == SCD_OFS_CTRL);

	always_comb begin
		next_r = r;

		// control register
		if (wr_ctrl) begin
			next_r.bus_mode = i_bus.wdata[SCD_CTL_BUS];
			if (i_bus.wdata[SCD_CTL_RESTART]) begin
				next_r.restart_tog = ~r.restart_tog;
			end
		end

		// take the flag word once the request toggle has settled
		if (req_q != r.ack_tog) begin
			next_r.status  = l.held;
			next_r.ack_tog = req_q;
		end

		// read data stands only in the cycle after the strobe
		next_r.rdata = SCD_RDATA_NONE;
		if (i_bus.rd) begin
			case (i_bus.addr)
				SCD_OFS_STATUS: begin
					next_r.rdata = r.status;
				end
				SCD_OFS_CTRL: begin
					next_r.rdata = {3'h0, r.bus_mode};
				end
				default: begin
					next_r.rdata = SCD_RDATA_NONE;
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			r <= SCD_REF_RST;
		end else if (i_ce) begin
			r <= next_r;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign o_rdata  = r.rdata;
	assign o_status = r.status;

endmodule

/* File: hw/scd_pkg.sv */
// package: constants and types of the serial clock counter block
package scd_pkg;

	// ------------------------------------------------------------
	// register bus
	// ------------------------------------------------------------
	localparam int           SCD_AW          = 4;
	localparam int           SCD_DW          = 4;
	localparam logic [3:0]   SCD_OFS_CTRL    = 4'hc;
	localparam logic [3:0]   SCD_OFS_STATUS  = 4'hd;
	localparam int           SCD_CTL_BUS     = 0;
	localparam int           SCD_CTL_RESTART = 1;
	localparam logic [3:0]   SCD_RDATA_NONE  = 4'h0;

	// ------------------------------------------------------------
	// counter and flags
	// ------------------------------------------------------------
	localparam int           SCD_CNT_W       = 4;
	localparam logic [3:0]   SCD_CNT_RST     = 4'h0;
	localparam logic [3:0]   SCD_CNT_ONE     = 4'h1;
	localparam logic [3:0]   SCD_CNT_EIGHT   = 4'h8;
	localparam logic [3:0]   SCD_CNT_NINE    = 4'h9;
	localparam int           SCD_SYNC_STAGES = 3;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [SCD_AW-1:0] addr;
		logic [SCD_DW-1:0] wdata;
		logic              wr;
		logic              rd;
	} scd_bus_req_t;

	// bit 3 down to bit 0 of the status register
	typedef struct packed {
		logic count_eight_flag;
		logic count_nine_flag;
		logic start_seen_flag;
		logic bus_busy_flag;
	} scd_flags_t;

	typedef enum logic [1:0] {
		SCD_TX_IDLE = 2'b01,
		SCD_TX_WAIT = 2'b10
	} scd_tx_t;

	typedef struct packed {
		logic                 scl_prev;
		logic                 sda_prev;
		logic [SCD_CNT_W-1:0] cnt;
		scd_flags_t           flags;
		scd_flags_t           held;
		logic                 req_tog;
		logic                 restart_seen;
		scd_tx_t              tx;
	} scd_link_t;

	typedef struct packed {
		logic                 bus_mode;
		logic                 restart_tog;
		logic                 ack_tog;
		scd_flags_t           status;
		logic [SCD_DW-1:0]    rdata;
	} scd_ref_t;

	localparam scd_flags_t SCD_FLAGS_RST = 4'h0;

	localparam scd_link_t SCD_LINK_RST = '{
		scl_prev:     1'b1,
		sda_prev:     1'b1,
		cnt:          SCD_CNT_RST,
		flags:        SCD_FLAGS_RST,
		held:         SCD_FLAGS_RST,
		req_tog:      1'b0,
		restart_seen: 1'b0,
		tx:           SCD_TX_IDLE
	};

	localparam scd_ref_t SCD_REF_RST = '{
		bus_mode:    1'b0,
		restart_tog: 1'b0,
		ack_tog:     1'b0,
		status:      SCD_FLAGS_RST,
		rdata:       SCD_RDATA_NONE
	};

endpackage

/* File: hw/scd_sync3.sv */
// module: three-stage synchroniser, a change counts when stages agree
module scd_sync3
	import scd_pkg::*;
#(
	parameter int W = 1
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	input  wire logic         i_en,
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} scd_sync_st_t;

	scd_sync_st_t st;
	scd_sync_st_t next_st;
	logic [W-1:0] next_q;

	// ------------------------------------------------------------
	// per-bit agreement of second and third stage
	// ------------------------------------------------------------
	for (genvar k = 0; k < W; k++) begin : g_bit
		assign next_q[k] = (st.s2[k] == st.s3[k]) ? st.s2[k] : st.q[k];
	end

	always_comb begin
		next_st    = st;
		next_st.s1 = i_d;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		next_st.q  = next_q;
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st <= '0;
		end else if (i_en) begin
			st <= next_st;
		end
	end

	assign o_q = st.q;

endmodule

/* File: dv/scd_peer.sv */
// peer on the two-wire bus: drives serial clock and data pins
module scd_peer (
	input  wire logic i_link_clk,
	output logic      o_scl,
	output logic      o_sda
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {o_scl, o_sda} = 2'b11;
	task automatic hold(int n);
		repeat (n) @(posedge i_link_clk);
	endtask
	// scl low then high; sda held, so no false start or stop
	task automatic pulses(int n);
		hold(1);
		repeat (n) begin
			o_scl <= 1'b0;
			hold(10);
			o_scl <= 1'b1;
			hold(25);
		end
	endtask
	// sda change with scl high: 0 is a start, 1 a stop
	task automatic data(logic v);
		hold(1);
		o_sda <= v;
		hold(10);
	endtask
endmodule

/* File: dv/scd_top_sva.sv */
// checker: read path and status flag relations at the top ports
module scd_top_sva
	import scd_pkg::*;
(
	input logic              i_ref_clk,
	input logic              i_rst,
	input logic              i_ce,
	input logic              i_link_clk,
	input scd_bus_req_t      i_bus,
	input logic              i_scl,
	input logic              i_sda,
	input logic [SCD_DW-1:0] o_rdata,
	input scd_flags_t        o_status
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	property p_rd_status;
		i_ce && i_bus.rd && i_bus.addr == SCD_OFS_STATUS
			|=> o_rdata == $past(o_status);
	endproperty
	a_rd_status: assert property (p_rd_status)
		else $error("status read wrong");
	property p_rd_other;
		i_ce && i_bus.rd && i_bus.addr != SCD_OFS_STATUS
			&& i_bus.addr != SCD_OFS_CTRL |=> o_rdata == 4'h0;
	endproperty
	a_rd_other: assert property (p_rd_other)
		else $error("unmapped read not zero");
	property p_excl;
		!(o_status[3] && o_status[2]);
	endproperty
	a_excl: assert property (p_excl)
		else $error("eight and nine both set");
	property p_busy_start;
		$rose(o_status[0]) |-> o_status[1];
	endproperty
	a_busy_start: assert property (p_busy_start)
		else $error("busy without start");
	property p_nine_eight;
		$rose(o_status[2]) |-> $fell(o_status[3]);
	endproperty
	a_nine_eight: assert property (p_nine_eight)
		else $error("nine not after eight");
	property p_start_clr;
		$fell(o_status[1]) |-> $fell(o_status[2]);
	endproperty
	a_start_clr: assert property (p_start_clr)
		else $error("start flag cleared off nine");
	property p_wr_ro;
		i_ce && i_bus.wr && i_bus.addr == SCD_OFS_STATUS
			|=> $stable(o_status);
	endproperty
	a_wr_ro: assert property (p_wr_ro)
		else $error("status written");
	property p_eight_scl;
		$rose(o_status[3]) |-> i_scl;
	endproperty
	a_eight_scl: assert property (p_eight_scl)
		else $error("eight off a rising edge");
endmodule

bind scd_top scd_top_sva u_sva (.i_ref_clk, .i_rst, .i_ce, .i_link_clk,
	.i_bus, .i_scl, .i_sda, .o_rdata, .o_status);

/* File: dv/tb.sv */
// testbench: table of frames, then register and reset cases
module tb
	import scd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic       mode;
		logic [4:0] n;
		logic [3:0] exp;
	} scd_row_t;
	localparam scd_row_t ROWS [7] = '{
		'{1'b1, 5'h00, 4'h3}, '{1'b1, 5'h08, 4'hb}, '{1'b1, 5'h09, 4'h7},
		'{1'b1, 5'h0a, 4'h1}, '{1'b0, 5'h08, 4'h8}, '{1'b0, 5'h09, 4'h0},
		'{1'b0, 5'h18, 4'h8}};
	logic         clk = 1'b0;
	logic         link = 1'b0;
	logic         rst = 1'b1;
	logic         ce = 1'b1;
	scd_bus_req_t bus = '0;
	logic [3:0]   d;
	scd_flags_t   st;
	logic         scl;
	logic         sda;
	int           checks = 0;
	int           fail_count = 0;
	always #10 clk = ~clk;
	always #6 link = ~link;
	scd_peer u_peer (.i_link_clk(link), .o_scl(scl), .o_sda(sda));
	scd_top dut (.i_ref_clk(clk), .i_rst(rst), .i_ce(ce),
		.i_link_clk(link), .i_bus(bus), .i_scl(scl), .i_sda(sda),
		.o_rdata(d), .o_status(st));
	task automatic wr(logic [3:0] a, logic [3:0] v);
		@(posedge clk);
		bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus <= '0;
	endtask
	task automatic rd_chk(logic [3:0] a, logic [3:0] exp);
		@(posedge clk);
		bus <= '{addr: a, wdata: 4'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus <= '0;
		#1;
		checks++;
		if (d !== exp) begin
			fail_count++;
			$display("[ERR] %0t read %h got %h exp %h", $time, a, d, exp);
		end
	endtask
	task automatic stat_chk(logic [3:0] exp);
		checks++;
		if (st !== exp) begin
			fail_count++;
			$display("[ERR] %0t status port %h exp %h", $time, st, exp);
		end
	endtask
	task automatic summarize();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		repeat (10) @(posedge clk);
		for (int i = 0; i < 7; i++) begin
			wr(SCD_OFS_CTRL, {3'h1, ROWS[i].mode});
			u_peer.data(1'b0);
			u_peer.pulses(ROWS[i].n);
			repeat (20) @(posedge clk);
			rd_chk(SCD_OFS_STATUS, ROWS[i].exp);
			stat_chk(ROWS[i].exp);
			u_peer.data(1'b1);
			repeat (20) @(posedge clk);
			rd_chk(SCD_OFS_STATUS, ROWS[i].exp & 4'he);
			stat_chk(ROWS[i].exp & 4'he);
		end
		wr(SCD_OFS_CTRL, 4'h1);
		rd_chk(SCD_OFS_CTRL, 4'h1);
		wr(SCD_OFS_STATUS, 4'hf);
		rd_chk(SCD_OFS_STATUS, 4'h8);
		stat_chk(4'h8);
		rd_chk(4'h3, 4'h0);
		@(posedge clk);
		ce <= 1'b0;
		wr(SCD_OFS_CTRL, 4'h0);
		ce <= 1'b1;
		rd_chk(SCD_OFS_CTRL, 4'h1);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (10) @(posedge clk);
		rd_chk(SCD_OFS_STATUS, 4'h0);
		stat_chk(4'h0);
		rd_chk(SCD_OFS_CTRL, 4'h0);
		summarize();
	end
	initial begin
		#400000;
		fail_count++;
		summarize();
	end
endmodule
